/* File: rtl/fspg_cfg.svh */
// constants for the flash self-program guard
`ifndef FSPG_CFG_SVH
`define FSPG_CFG_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FSPG_OFF_CTRL 32'h0000_0000
`define FSPG_OFF_ADDR 32'h0000_0004
// ----------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------
`define FSPG_BIT_ARM 0
`define FSPG_BIT_BUSY 1
`define FSPG_BIT_HALT 2
`define FSPG_BIT_REFUSED 3
// ----------------------------------------------------------------------
// reset values and geometry defaults
// ----------------------------------------------------------------------
`define FSPG_CTRL_RST 4'h0
`define FSPG_ADDR_W 15
`define FSPG_HALT_WORDS 4096
`define FSPG_BOOT_MIN_WORDS 512
`endif

/* File: rtl/fspg_pkg.sv */
// types for the flash self-program guard
`default_nettype none
package fspg_pkg;
   // one-hot sequencer states
   typedef enum logic [2:0] {
      FSPG_IDLE = 3'b001,
      FSPG_LIVE = 3'b010,
      FSPG_HALT = 3'b100
   } fspg_state_t;
   // flash operation kinds
   typedef enum logic [1:0] {
      FSPG_OP_NONE = 2'h0,
      FSPG_OP_ERASE = 2'h1,
      FSPG_OP_WRITE = 2'h2
   } fspg_op_t;
endpackage
`default_nettype wire

/* File: rtl/fspg_guard.sv */
// self-program guard: section checks, cpu stall and busy flag
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fspg_cfg.svh"
module fspg_guard
   import fspg_pkg::*;
#(
   parameter int AW = `FSPG_ADDR_W,
   parameter int HALT_WORDS = `FSPG_HALT_WORDS,
   parameter int BOOT_MIN_WORDS = `FSPG_BOOT_MIN_WORDS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   // fuse and lock pins
   input wire logic [1:0] boot_size_fuses_i,
   input wire logic [1:0] lock_set0_i,
   input wire logic [1:0] lock_set1_i,
   // cpu side
   input wire logic store_req_i,
   input wire fspg_op_t store_op_i,
   input wire logic [AW-1:0] store_pc_i,
   input wire logic [AW-1:0] store_target_i,
   output logic cpu_halt_o,
   output logic live_read_blocked_o,
   // flash array side
   input wire logic flash_done_i,
   output logic flash_start_o,
   output fspg_op_t flash_op_o,
   output logic [AW-1:0] flash_addr_o
);
   // ----------------------------------------------------------------------
   // geometry checks
   // ----------------------------------------------------------------------
   localparam logic [AW:0] FLASH_WORDS = (AW+1)'(1) << AW;
   localparam logic [AW:0] HALT_START = FLASH_WORDS - (AW+1)'(HALT_WORDS);
   // largest boot size must fit inside the halting section
   if (AW < 13 || AW > 24) begin : g_bad_aw
      $error("fspg_guard: AW out of range");
   end
   if (BOOT_MIN_WORDS * 8 > HALT_WORDS) begin : g_bad_boot
      $error("fspg_guard: boot section exceeds halting section");
   end
   if (HALT_WORDS >= (1 << AW)) begin : g_bad_halt
      $error("fspg_guard: halting section too large");
   end

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] fuse_s1;
      logic [1:0] fuse_s2;
      logic [1:0] lk0_s1;
      logic [1:0] lk0_s2;
      logic [1:0] lk1_s1;
      logic [1:0] lk1_s2;
      fspg_state_t st;
      logic arm;
      logic busy;
      logic refused;
      logic start;
      fspg_op_t op;
      logic [AW-1:0] addr;
      logic dp_act;
      logic dp_wr;
      logic [2:0] dp_idx;
      logic [31:0] rdata;
   } fspg_regs_t;

   fspg_regs_t r;
   fspg_regs_t next_r;
   logic rst_s1;
   logic rst_n;

   // reset release through two flops
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ----------------------------------------------------------------------
   // section decode
   // ----------------------------------------------------------------------
   logic [AW:0] boot_start;
   logic pc_in_boot;
   logic tgt_in_boot;
   logic tgt_in_halt;
   logic write_locked;
   logic accept;
   logic ctrl_wr;
   logic [3:0] ctrl_rd;

   always_comb begin
      // boot size from fuses only; 11 is smallest, 00 largest
      boot_start = FLASH_WORDS -
         ((AW+1)'(BOOT_MIN_WORDS) << (2'h3 - r.fuse_s2));
      pc_in_boot = {1'b0, store_pc_i} >= boot_start;
      tgt_in_boot = {1'b0, store_target_i} >= boot_start;
      tgt_in_halt = {1'b0, store_target_i} >= HALT_START;
      // programmed low bit of a lock set forbids writes to its section
      write_locked = tgt_in_boot ? !r.lk1_s2[0] : !r.lk0_s2[0];
      accept = store_req_i && r.arm && pc_in_boot && !write_locked &&
         (store_op_i != FSPG_OP_NONE) && (r.st == FSPG_IDLE);
   end

   // ----------------------------------------------------------------------
   // bus decode helpers
   // ----------------------------------------------------------------------
   assign ctrl_wr = r.dp_act && r.dp_wr && (r.dp_idx == 3'h0);
   assign ctrl_rd = {r.refused, (r.st == FSPG_HALT), r.busy, r.arm};

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.fuse_s1 = boot_size_fuses_i;
      next_r.fuse_s2 = r.fuse_s1;
      next_r.lk0_s1 = lock_set0_i;
      next_r.lk0_s2 = r.lk0_s1;
      next_r.lk1_s1 = lock_set1_i;
      next_r.lk1_s2 = r.lk1_s1;
      next_r.start = 1'b0;

      // register writes in the data phase
      if (ctrl_wr) begin
         next_r.arm = hwdata_i[`FSPG_BIT_ARM];
         // writing one clears the busy flag, only once the array is idle
         if (hwdata_i[`FSPG_BIT_BUSY] && r.st == FSPG_IDLE) begin
            next_r.busy = 1'b0;
         end
         if (hwdata_i[`FSPG_BIT_REFUSED]) begin
            next_r.refused = 1'b0;
         end
      end

      // sequencer
      unique case (r.st)
         FSPG_IDLE: begin
            if (accept) begin
               next_r.addr = store_target_i;
               next_r.op = store_op_i;
               next_r.start = 1'b1;
               next_r.arm = 1'b0;
               if (tgt_in_halt) begin
                  next_r.st = FSPG_HALT;
               end else begin
                  next_r.st = FSPG_LIVE;
                  next_r.busy = 1'b1;
               end
            end else if (store_req_i) begin
               next_r.refused = 1'b1;
            end
         end
         FSPG_LIVE: begin
            next_r.busy = 1'b1;
            if (flash_done_i) begin
               next_r.st = FSPG_IDLE;
            end
         end
         FSPG_HALT: begin
            if (flash_done_i) begin
               next_r.st = FSPG_IDLE;
            end
         end
         default: begin
            next_r.st = FSPG_IDLE;
         end
      endcase

      // address phase capture and registered read data
      next_r.dp_act = hsel_i && htrans_i[1] && hready_i;
      next_r.dp_wr = hwrite_i;
      // addresses above the register window must not alias onto them
      next_r.dp_idx = (haddr_i[31:5] == 27'h0) ? haddr_i[4:2] : 3'h7;
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
         if (haddr_i == `FSPG_OFF_CTRL) begin
            next_r.rdata = {28'h0, ctrl_rd};
         end else if (haddr_i == `FSPG_OFF_ADDR) begin
            next_r.rdata = 32'(r.addr);
         end else begin
            next_r.rdata = 32'h0;
         end
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= FSPG_IDLE;
         r.op <= FSPG_OP_NONE;
         r.fuse_s1 <= 2'h3;
         r.fuse_s2 <= 2'h3;
         r.lk0_s1 <= 2'h3;
         r.lk0_s2 <= 2'h3;
         r.lk1_s1 <= 2'h3;
         r.lk1_s2 <= 2'h3;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = r.rdata;
   assign cpu_halt_o = (r.st == FSPG_HALT);
   assign live_read_blocked_o = r.busy;
   assign flash_start_o = r.start;
   assign flash_op_o = r.op;
   assign flash_addr_o = r.addr;

endmodule // fspg_guard
`default_nettype wire

/* File: sim/fspg_guard_checker.sv */
// assertions on the ports of the self-program guard
`timescale 1ns/1ps
`default_nettype none
module fspg_guard_checker #(
   parameter int AW = 15,
   parameter int HALT_WORDS = 4096
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // cpu and flash side
   input wire logic store_req_i,
   input wire logic [AW-1:0] store_pc_i,
   input wire logic [AW-1:0] store_target_i,
   input wire logic cpu_halt_o,
   input wire logic live_read_blocked_o,
   input wire logic flash_done_i,
   input wire logic flash_start_o,
   input wire logic [AW-1:0] flash_addr_o
);
   // first word of the halting section
   localparam int NS = (1 << AW) - HALT_WORDS;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   start_needs_req_a: assert property (
      flash_start_o |-> $past(store_req_i))
      else $error("start without a store request");
   halt_section_a: assert property (
      flash_start_o && flash_addr_o >= NS |-> cpu_halt_o)
      else $error("no halt for a halting section op");
   live_stays_up_a: assert property (
      flash_start_o && flash_addr_o < NS |->
      live_read_blocked_o && !cpu_halt_o)
      else $error("wrong stall or busy on a readable op");
   halt_holds_a: assert property (
      cpu_halt_o && !flash_done_i |=> cpu_halt_o)
      else $error("halt dropped before done");
   halt_release_a: assert property (
      cpu_halt_o && flash_done_i |=> !cpu_halt_o)
      else $error("halt kept after done");
   addr_latch_a: assert property (
      flash_start_o |-> flash_addr_o == $past(store_target_i))
      else $error("target not latched");
   addr_hold_a: assert property (
      cpu_halt_o && !flash_start_o |-> $stable(flash_addr_o))
      else $error("target moved during op");
   app_refuse_a: assert property (
      store_req_i && store_pc_i < NS |=> !flash_start_o)
      else $error("store from application started");
   cover property (flash_start_o && cpu_halt_o);
   cover property (flash_start_o && live_read_blocked_o);
   cover property (store_req_i ##1 !flash_start_o);
endmodule // fspg_guard_checker
bind fspg_guard fspg_guard_checker #(.AW(AW), .HALT_WORDS(HALT_WORDS)) chk (
   .clk_i(clk_i), .nrst_i(nrst_i), .store_req_i(store_req_i),
   .store_pc_i(store_pc_i), .store_target_i(store_target_i),
   .cpu_halt_o(cpu_halt_o), .live_read_blocked_o(live_read_blocked_o),
   .flash_done_i(flash_done_i), .flash_start_o(flash_start_o),
   .flash_addr_o(flash_addr_o));
`default_nettype wire

/* File: sim/fspg_flash_model.sv */
// flash array model: answers each start that has a nonzero lat_i with a done pulse
`timescale 1ns/1ps
`default_nettype none
module fspg_flash_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // guard side
   input wire logic flash_start_i,
   input wire logic [7:0] lat_i,
   output logic flash_done_o
);
   logic [7:0] cnt;
   // count down from the start, pulse done as it reaches zero
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt <= 8'h00;
         flash_done_o <= 1'b0;
      end else begin
         flash_done_o <= (cnt == 8'h01);
         if (flash_start_i) cnt <= lat_i;
         else if (cnt != 8'h00) cnt <= cnt - 8'h01;
      end
   end
endmodule // fspg_flash_model
`default_nettype wire

/* File: sim/flash_self_program_guard_tb.sv */
// testbench for the self-program guard
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_guard_tb;
   import fspg_pkg::*;
   logic clk_i = 1'b0, nrst_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic store_req_i = 1'b0, hreadyout_o, hresp_o, cpu_halt_o;
   logic live_read_blocked_o, flash_done_i, flash_start_o;
   logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o;
   logic [1:0] htrans_i = '0, fuse = 2'h3, lk0 = 2'h3, lk1 = 2'h3;
   logic [14:0] store_pc_i = '0, store_target_i = '0, flash_addr_o;
   logic [7:0] lat = 8'd20;
   fspg_op_t store_op_i = FSPG_OP_NONE, flash_op_o;
   int n_mismatch = 0, checks_done = 0;
   always #4 clk_i = ~clk_i;
   fspg_guard uut (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
      .boot_size_fuses_i(fuse), .lock_set0_i(lk0), .lock_set1_i(lk1),
      .store_req_i(store_req_i), .store_op_i(store_op_i),
      .store_pc_i(store_pc_i), .store_target_i(store_target_i),
      .cpu_halt_o(cpu_halt_o), .live_read_blocked_o(live_read_blocked_o),
      .flash_done_i(flash_done_i), .flash_start_o(flash_start_o),
      .flash_op_o(flash_op_o), .flash_addr_o(flash_addr_o));
   fspg_flash_model fm (.clk_i(clk_i), .nrst_i(nrst_i),
      .flash_start_i(flash_start_o), .lat_i(lat),
      .flash_done_o(flash_done_i));
   task automatic chk(input string nm, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   // one single-word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      r = hrdata_o;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [31:0] a, e);
      logic [31:0] r;
      bus(1'b0, a, '0, r);
      chk($sformatf("reg%0h", a), r, e);
      chk("resp", {hreadyout_o, hresp_o}, 32'h2);
   endtask
   // one store-program request, then look at the start pulse
   task automatic issue(input logic [14:0] p, t, input fspg_op_t o,
                        input logic ok);
      @(posedge clk_i);
      store_req_i <= 1'b1;
      store_pc_i <= p;
      store_target_i <= t;
      store_op_i <= o;
      @(posedge clk_i);
      store_req_i <= 1'b0;
      #1 chk("start", flash_start_o, ok);
      if (ok) chk("op", flash_op_o, o);
      if (ok) chk("addr", flash_addr_o, t);
   endtask
   task automatic done_wait;
      wait (flash_done_i === 1'b1);
      @(posedge clk_i);
      #1;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20000 n_mismatch++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rd(32'h0, 32'h0);
      rd(32'h4, 32'h0);
      wr(32'h0, 32'h1);
      issue(15'h0100, 15'h0200, FSPG_OP_WRITE, 1'b0);
      rd(32'h0, 32'h9);
      wr(32'h0, 32'h9);
      issue(15'h7f00, 15'h0100, FSPG_OP_ERASE, 1'b1);
      chk("blocked", live_read_blocked_o, 1'b1);
      rd(32'h0, 32'h2);
      rd(32'h4, 32'h100);
      done_wait();
      rd(32'h0, 32'h2);
      wr(32'h0, 32'h3);
      issue(15'h7f00, 15'h7f40, FSPG_OP_WRITE, 1'b1);
      chk("halt", cpu_halt_o, 1'b1);
      rd(32'h0, 32'h4);
      done_wait();
      chk("halt", cpu_halt_o, 1'b0);
      @(posedge clk_i);
      lk1 <= 2'h2;
      repeat (4) @(posedge clk_i);
      wr(32'h0, 32'h1);
      issue(15'h7f00, 15'h7f40, FSPG_OP_WRITE, 1'b0);
      wr(32'h0, 32'h9);
      issue(15'h7f00, 15'h0200, FSPG_OP_WRITE, 1'b1);
      done_wait();
      wr(32'h0, 32'h3);
      lk1 <= 2'h3;
      fuse <= 2'h0;
      lat <= 8'd1;
      repeat (4) @(posedge clk_i);
      issue(15'h7100, 15'h0300, FSPG_OP_ERASE, 1'b1);
      done_wait();
      wr(32'h0, 32'h3);
      fuse <= 2'h3;
      repeat (4) @(posedge clk_i);
      issue(15'h7100, 15'h0300, FSPG_OP_ERASE, 1'b0);
      rd(32'h0, 32'h9);
      lk0 <= 2'h2;
      repeat (4) @(posedge clk_i);
      wr(32'h0, 32'h9);
      issue(15'h7f00, 15'h0200, FSPG_OP_WRITE, 1'b0);
      rd(32'h0, 32'h9);
      rd(32'h8, 32'h0);
      close_out();
   end
endmodule // flash_self_program_guard_tb
`default_nettype wire
